// file: core/mie_alu.sv
// Arithmetic and logic unit for the byte-wide execute block.
module mie_alu
    import mie_pkg::*;
(
    input wire mie_alu_e sel_i,
    input wire logic [7:0] opd_i,
    input wire logic [7:0] acc_i,
    input wire logic carry_i,
    output logic [7:0] res_o,
    output logic carry_o,
    output logic dcarry_o,
    output logic zero_o
);

    // Subtraction adds the complement plus one, so a carry out means
    // that no borrow occurred.
    wire [8:0] diff = {1'b0, opd_i} + {1'b0, ~acc_i} + 9'h001;
    wire [4:0] ndiff = {1'b0, opd_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;

    assign res_o = (sel_i == ALU_SUB) ? diff[7:0] :
        (sel_i == ALU_XOR) ? (opd_i ^ acc_i) :
        (sel_i == ALU_RLC) ? {opd_i[6:0], carry_i} :
        (sel_i == ALU_RRC) ? {carry_i, opd_i[7:1]} :
        (sel_i == ALU_SWAP) ? {opd_i[3:0], opd_i[7:4]} :
        opd_i;
    assign carry_o = (sel_i == ALU_SUB) ? diff[8] :
        (sel_i == ALU_RLC) ? opd_i[7] :
        (sel_i == ALU_RRC) ? opd_i[0] : carry_i;
    assign dcarry_o = ndiff[4];
    assign zero_o = (res_o == 8'h00);

endmodule : mie_alu

// file: core/mie_core.sv
// Instruction execute core with its AXI4-Lite register slave.
module mie_core
    import mie_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [15:0] rom_addr_o,
    output logic rom_rd_o,
    input wire logic [15:0] rom_data_i,
    input wire logic wake_i,
    output logic sleep_o
);

    // ****************
    // Helpers
    // ****************
    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [15:0] nv, input logic [1:0] strb);
        merge16 = {strb[1] ? nv[15:8] : old[15:8],
            strb[0] ? nv[7:0] : old[7:0]};
    endfunction : merge16

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OFF_INSTR) || (a == OFF_STATUS) ||
            (a == OFF_ACC) || (a == OFF_PC) || (a == OFF_TPTR_LO) ||
            (a == OFF_TPTR_HI) || (a == OFF_TLATCH) ||
            (a == OFF_FADDR) || (a == OFF_FDATA) ||
            (a == OFF_STACK) || (a == OFF_DEPTH);
    endfunction : is_mapped

    // ****************
    // Architectural state
    // ****************
    mie_state_e state;
    logic [15:0] instr;
    logic [12:0] pc;
    logic [7:0] acc;
    logic [7:0] tptr_lo;
    logic [7:0] tptr_hi;
    logic [7:0] tlatch;
    logic [8:0] faddr;
    logic c_flag;
    logic dc_flag;
    logic z_flag;
    logic to_flag;
    logic pd_flag;
    logic global_irq_enable;
    logic [3:0] sp;
    logic [7:0] file_mem [FILE_DEPTH];
    logic [12:0] stack_mem [STACK_DEPTH];
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // ****************
    // Decode
    // ****************
    wire [3:0] opn = instr[11:8];
    wire [7:0] lit = instr[7:0];
    wire dir = instr[7];
    wire [8:0] ex_faddr = {instr[15:14], instr[6:0]};
    wire is_ljmp = (instr[13:11] == LJMP_TAG);
    wire is_lit = (instr[15:12] == LGRP_TAG);
    wire is_fgrp = (instr[13:12] == FGRP_TAG);
    wire f_store = is_fgrp && opn == FOP_STORE && dir;
    wire f_sub = is_fgrp && opn == FOP_SUB;
    wire f_xor = is_fgrp && opn == FOP_XOR;
    wire f_move = is_fgrp && opn == FOP_MOVE;
    wire f_rrc = is_fgrp && opn == FOP_RRC;
    wire f_rlc = is_fgrp && opn == FOP_RLC;
    wire f_swap = is_fgrp && opn == FOP_SWAP;
    wire l_exit = is_lit && opn == LOP_EXIT;
    wire l_load = is_lit && opn == LOP_LOAD;
    wire l_xor = is_lit && opn == LOP_XOR;
    wire l_sub = is_lit && opn == LOP_SUB;
    wire s_sleep = (instr == OPC_SLEEP);
    wire s_ret = (instr == OPC_SUB_EXIT);
    wire s_interrupt_exit = (instr == OPC_IRQ_EXIT);
    wire s_tabl = (instr == OPC_TAB_LOW);
    wire s_tabh = (instr == OPC_TAB_HIGH);
    wire s_tab = s_tabl || s_tabh;
    wire f_res = f_sub || f_xor || f_move || f_rrc || f_rlc || f_swap;

    // ****************
    // Execute
    // ****************
    wire ex = (state == ST_EXEC);
    wire sec = (state == ST_SECOND);
    wire [7:0] fval = file_mem[ex_faddr];
    wire [3:0] sp_dec = (sp == 4'h0) ? 4'h0 : sp - 4'h1;
    wire [12:0] stack_top = stack_mem[sp_dec[2:0]];
    mie_alu_e alu_sel;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_dc;
    logic alu_z;

    assign alu_sel = (f_sub || l_sub) ? ALU_SUB :
        (f_xor || l_xor) ? ALU_XOR :
        f_rlc ? ALU_RLC :
        f_rrc ? ALU_RRC :
        f_swap ? ALU_SWAP : ALU_PASS;

    mie_alu u_alu (
        .sel_i(alu_sel),
        .opd_i(is_lit ? lit : fval),
        .acc_i(acc),
        .carry_i(c_flag),
        .res_o(alu_res),
        .carry_o(alu_c),
        .dcarry_o(alu_dc),
        .zero_o(alu_z)
    );

    // Words outside the implemented subset fall through as idle_op.
    wire ex_pop = ex && (s_ret || s_interrupt_exit || l_exit);
    wire ex_two = ex && (is_ljmp || ex_pop || s_tab);
    wire ex_acc_we = ex && ((f_res && !dir) || l_load || l_xor ||
        l_sub || l_exit);
    wire [7:0] ex_acc_val = (l_load || l_exit) ? lit : alu_res;
    wire ex_file_we = ex && ((f_res && dir) || f_store);
    wire [7:0] ex_file_val = f_store ? acc : alu_res;
    wire ex_c_we = ex && (f_sub || l_sub || f_rlc || f_rrc);
    wire ex_dc_we = ex && (f_sub || l_sub);
    wire ex_z_we = ex && (f_sub || l_sub || f_xor || l_xor || f_move);
    wire [12:0] ex_pc_val = is_ljmp ? {instr[15:14], instr[10:0]} :
        ex_pop ? stack_top : pc + 13'h0001;
    wire tab_we = sec && s_tab;
    wire [7:0] tab_val = s_tabh ? rom_data_i[15:8] : rom_data_i[7:0];

    // ****************
    // Register bus decode
    // ****************
    wire wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
    wire busy = ex || sec;
    // Writes that would race the executing instruction are refused.
    wire wr_ok = is_mapped(aw_addr) && !busy &&
        !(state == ST_SLEEP && aw_addr == OFF_INSTR);
    wire sw_we = wr_fire && wr_ok;
    wire [15:0] wd = w_data[15:0];
    wire [1:0] ws = w_strb[1:0];
    wire [7:0] status_rd = {state == ST_SLEEP, busy, global_irq_enable, to_flag,
        pd_flag, z_flag, dc_flag, c_flag};
    wire [15:0] st_new = merge16({8'h00, status_rd}, wd, ws);
    wire we_instr = sw_we && aw_addr == OFF_INSTR;
    wire we_status = sw_we && aw_addr == OFF_STATUS;
    wire we_acc = sw_we && aw_addr == OFF_ACC;
    wire we_pc = sw_we && aw_addr == OFF_PC;
    wire we_tlo = sw_we && aw_addr == OFF_TPTR_LO;
    wire we_thi = sw_we && aw_addr == OFF_TPTR_HI;
    wire we_faddr = sw_we && aw_addr == OFF_FADDR;
    wire we_fdata = sw_we && aw_addr == OFF_FDATA;
    wire we_stack = sw_we && aw_addr == OFF_STACK && sp != STACK_FULL;
    wire [7:0] ra = s_axi_araddr_i;
    wire [15:0] rd_val = (ra == OFF_INSTR) ? instr :
        (ra == OFF_STATUS) ? {8'h00, status_rd} :
        (ra == OFF_ACC) ? {8'h00, acc} :
        (ra == OFF_PC) ? {3'h0, pc} :
        (ra == OFF_TPTR_LO) ? {8'h00, tptr_lo} :
        (ra == OFF_TPTR_HI) ? {8'h00, tptr_hi} :
        (ra == OFF_TLATCH) ? {8'h00, tlatch} :
        (ra == OFF_FADDR) ? {7'h00, faddr} :
        (ra == OFF_FDATA) ? {8'h00, file_mem[faddr]} :
        (ra == OFF_STACK) ? {3'h0, stack_top} :
        (ra == OFF_DEPTH) ? {12'h000, sp} : 16'h0000;

    // ****************
    // AXI4-Lite handshakes
    // ****************
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                s_axi_awready_o <= 1'b0;
                aw_addr <= {s_axi_awaddr_i[7:2], 2'b00};
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_awready_o <= 1'b1;
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                s_axi_wready_o <= 1'b0;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_wready_o <= 1'b1;
            if (wr_fire)
            begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= RESP_OKAY;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {16'h0000, rd_val};
            s_axi_rresp_o <= is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid_o && s_axi_rready_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // ****************
    // Sequencer
    // ****************
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            state <= ST_IDLE;
        else
        begin
            unique case (state)
                ST_IDLE: if (we_instr) state <= ST_EXEC;
                ST_EXEC: state <= s_sleep ? ST_SLEEP :
                    ex_two ? ST_SECOND : ST_IDLE;
                ST_SECOND: state <= ST_IDLE;
                ST_SLEEP: if (wake_i) state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sleep_o <= 1'b0;
            rom_rd_o <= 1'b0;
            rom_addr_o <= 16'h0000;
        end
        else
        begin
            sleep_o <= (ex && s_sleep) || (state == ST_SLEEP && !wake_i);
            rom_rd_o <= ex && s_tab;
            if (ex && s_tab)
                rom_addr_o <= {tptr_hi, tptr_lo};
        end
    end

    // ****************
    // Registers written by software or by execution
    // ****************
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            instr <= RST_INSTR;
            pc <= RST_PC;
            acc <= RST_BYTE;
            tptr_lo <= RST_BYTE;
            tptr_hi <= RST_BYTE;
            tlatch <= RST_BYTE;
            faddr <= 9'h000;
        end
        else
        begin
            if (we_instr)
                instr <= merge16(instr, wd, ws);
            if (we_pc)
                pc <= 13'(merge16({3'h0, pc}, wd, ws));
            else if (ex)
                pc <= ex_pc_val;
            if (we_acc)
                acc <= 8'(merge16({8'h00, acc}, wd,
                    ws));
            else if (ex_acc_we)
                acc <= ex_acc_val;
            else if (tab_we)
                acc <= tab_val;
            if (tab_we)
                tlatch <= tab_val;
            if (we_tlo && ws[0])
                tptr_lo <= wd[7:0];
            if (we_thi && ws[0])
                tptr_hi <= wd[7:0];
            if (we_faddr)
                faddr <= 9'(merge16({7'h00, faddr}, wd, ws));
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            c_flag <= 1'b0;
            dc_flag <= 1'b0;
            z_flag <= 1'b0;
            to_flag <= RST_TO;
            pd_flag <= RST_PD;
            global_irq_enable <= RST_GIE;
        end
        else if (we_status)
        begin
            c_flag <= st_new[SB_C];
            dc_flag <= st_new[SB_DC];
            z_flag <= st_new[SB_Z];
            to_flag <= st_new[SB_TO];
            pd_flag <= st_new[SB_PD];
            global_irq_enable <= st_new[SB_GIE];
        end
        else
        begin
            if (ex_c_we)
                c_flag <= alu_c;
            if (ex_dc_we)
                dc_flag <= alu_dc;
            if (ex_z_we)
                z_flag <= alu_z;
            if (ex && s_sleep)
            begin
                to_flag <= SLEEP_TO_VAL;
                pd_flag <= SLEEP_PD_VAL;
            end
            if (ex && s_interrupt_exit)
                global_irq_enable <= 1'b1;
        end
    end

    // File memory and return stack hold no reset; software loads them.
    always_ff @(posedge clk_sys_i)
    begin
        if (we_fdata && ws[0])
            file_mem[faddr] <= wd[7:0];
        else if (ex_file_we)
            file_mem[ex_faddr] <= ex_file_val;
        if (we_stack)
            stack_mem[sp[2:0]] <= wd[12:0];
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            sp <= 4'h0;
        else if (we_stack)
            sp <= sp + 4'h1;
        else if (ex_pop)
            sp <= sp_dec;
    end

endmodule : mie_core

// file: core/mie_pkg.sv
// Constants, types and opcode encodings for the instruction execute block.
// Contract
// - long_jump loads PC, no flags, two cycles.
// - move_file copies file to acc or itself.
// - load_literal_acc sets acc, flags untouched, one cycle.
// - store_acc_to_file writes acc to file, no flags.
// - all-zero word is idle_op, one cycle.
// - subroutine_exit pops stack into PC, two cycles.
// - interrupt_exit pops stack, sets global_irq_enable.
// - exit_with_literal loads acc and PC, two cycles.
// - rotate_left_carry rotates file left through carry.
// - rotate_right_carry rotates file right through carry.
// - sleep enters power-down, updates expiry and power flags.
// - literal_minus_acc computes literal minus acc, flags.
// - file_minus_acc, carry set means no borrow.
// - nibble_exchange swaps file nibbles, flags unchanged.
// - table_read_high loads ROM upper byte, two cycles.
// - table_read_low loads ROM lower byte, two cycles.
// - zero_test sets zero_flag when file is zero.
// - xor_literal_acc XORs literal into acc, updates Z.
// - xor_acc_file XORs acc and file, direction selects.
// - file address is 9 bits from opcode.
package mie_pkg;

    // ****************
    // Register map
    // ****************
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_ACC = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0C;
    localparam logic [7:0] OFF_TPTR_LO = 8'h10;
    localparam logic [7:0] OFF_TPTR_HI = 8'h14;
    localparam logic [7:0] OFF_TLATCH = 8'h18;
    localparam logic [7:0] OFF_FADDR = 8'h1C;
    localparam logic [7:0] OFF_FDATA = 8'h20;
    localparam logic [7:0] OFF_STACK = 8'h24;
    localparam logic [7:0] OFF_DEPTH = 8'h28;

    // Status register bit positions.
    localparam int unsigned SB_C = 0;
    localparam int unsigned SB_DC = 1;
    localparam int unsigned SB_Z = 2;
    localparam int unsigned SB_PD = 3;
    localparam int unsigned SB_TO = 4;
    localparam int unsigned SB_GIE = 5;
    localparam int unsigned SB_BUSY = 6;
    localparam int unsigned SB_SLEEP = 7;

    // ****************
    // Reset values and sizes
    // ****************
    localparam logic [15:0] RST_INSTR = 16'h0000;
    localparam logic [12:0] RST_PC = 13'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic RST_TO = 1'b1;
    localparam logic RST_PD = 1'b1;
    localparam logic RST_GIE = 1'b0;
    localparam logic SLEEP_TO_VAL = 1'b1;
    localparam logic SLEEP_PD_VAL = 1'b0;
    localparam int unsigned STACK_DEPTH = 8;
    localparam logic [3:0] STACK_FULL = 4'h8;
    localparam int unsigned FILE_DEPTH = 512;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ****************
    // Opcode encodings
    // ****************
    localparam logic [15:0] OPC_SUB_EXIT = 16'h0040;
    localparam logic [15:0] OPC_IRQ_EXIT = 16'h0060;
    localparam logic [15:0] OPC_TAB_LOW = 16'h0050;
    localparam logic [15:0] OPC_TAB_HIGH = 16'h0058;
    localparam logic [15:0] OPC_SLEEP = 16'h1E03;
    localparam logic [2:0] LJMP_TAG = 3'h5;
    localparam logic [1:0] FGRP_TAG = 2'h0;
    localparam logic [3:0] LGRP_TAG = 4'h1;
    localparam logic [3:0] FOP_STORE = 4'h0;
    localparam logic [3:0] FOP_SUB = 4'h2;
    localparam logic [3:0] FOP_XOR = 4'h6;
    localparam logic [3:0] FOP_MOVE = 4'h8;
    localparam logic [3:0] FOP_RRC = 4'hC;
    localparam logic [3:0] FOP_RLC = 4'hD;
    localparam logic [3:0] FOP_SWAP = 4'hE;
    localparam logic [3:0] LOP_EXIT = 4'h8;
    localparam logic [3:0] LOP_LOAD = 4'h9;
    localparam logic [3:0] LOP_XOR = 4'hD;
    localparam logic [3:0] LOP_SUB = 4'hF;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND, ST_SLEEP}
        mie_state_e;
    typedef enum logic [2:0] {
        ALU_PASS, ALU_SUB, ALU_XOR, ALU_RLC, ALU_RRC, ALU_SWAP
    } mie_alu_e;

endpackage : mie_pkg

// file: tb/mie_rom_model.sv
// Behavioural program memory answering the core's table fetches.
module mie_rom_model
(
    input wire logic clk_sys_i,
    input wire logic [15:0] rom_addr_i,
    input wire logic rom_rd_i,
    output logic [15:0] rom_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last = 16'h0000;
    logic [15:0] word;
    // Halves differ per address so a swapped byte lane cannot pass.
    assign word = {rom_addr_i[7:0], ~rom_addr_i[7:0]};
    // Off the fetch cycle the bus shows the inverse of the last word.
    assign rom_data_o = rom_rd_i ? word : ~last;
    always_ff @(posedge clk_sys_i)
    begin
        if (rom_rd_i)
            last <= word;
    end
endmodule : mie_rom_model

// file: tb/mie_sva.sv
// Port-level checker for the instruction execute core.
module mie_sva
    import mie_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic [15:0] rom_addr_o,
    input wire logic rom_rd_o,
    input wire logic wake_i,
    input wire logic sleep_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    logic wfire;
    logic rfire;
    logic iwr;
    logic [15:0] op;
    assign wfire = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o;
    assign rfire = s_axi_arvalid_i && s_axi_arready_o;
    // A write to the instruction word while awake starts execution.
    assign iwr = wfire && s_axi_awaddr_i == OFF_INSTR && !sleep_o;
    assign op = s_axi_wdata_i[15:0];

    AST_BRESP: assert property (wfire |-> ##[1:3] s_axi_bvalid_o)
        else $error("write response missing");
    AST_RLAT: assert property (rfire |=> s_axi_rvalid_o)
        else $error("read data late");
    AST_RUPPER: assert property
        (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    AST_UNMAP: assert property (rfire && s_axi_araddr_i > OFF_DEPTH
        |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0)
        else $error("unmapped read not refused");
    AST_TAB: assert property (iwr && (op == OPC_TAB_LOW || op == OPC_TAB_HIGH)
        |-> ##[1:4] rom_rd_o)
        else $error("table read issued no fetch");
    AST_ROMPULSE: assert property (rom_rd_o |=> !rom_rd_o)
        else $error("fetch strobe longer than one cycle");
    AST_ROMADDR: assert property (rom_rd_o |=> $stable(rom_addr_o))
        else $error("fetch address moved during fetch");
    AST_SLEEP: assert property (iwr && op == OPC_SLEEP
        |-> ##[1:4] sleep_o)
        else $error("power-down not entered");
    AST_STAY: assert property (sleep_o && !wake_i |=> sleep_o)
        else $error("left power-down without wake");
    AST_QUIET: assert property (sleep_o |-> !rom_rd_o)
        else $error("fetch while powered down");

    cover property (rom_rd_o);
    cover property ($rose(sleep_o));
    cover property (rfire && s_axi_araddr_i > OFF_DEPTH);
endmodule : mie_sva

bind mie_core mie_sva chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .rom_addr_o(rom_addr_o),
    .rom_rd_o(rom_rd_o), .wake_i(wake_i), .sleep_o(sleep_o));

// file: tb/test_mie_core.sv
// Self-checking bench for the instruction execute core.
module test_mie_core
    import mie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] a, f;
        logic [3:0] s;
        logic [15:0] op;
        logic [7:0] ea, ef;
        logic [3:0] es;
        logic [15:0] pc;
    } mie_row_s;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] aa = 8'h00, ra = 8'h00;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0, wk = 1'b0;
    logic [31:0] wd = 32'h0, rdata, q;
    logic awr, wr_r, bv, arr, rv, rom_rd, slp;
    logic [1:0] bresp, rresp, r;
    logic [15:0] rom_addr, rom_d;
    int n_errors = 0, n_checks = 0;
    // Fields: acc, file, flags, opcode, acc, file, flags, pc after.
    mie_row_s rows [20] = '{
        72'h00_11_5_195A_5A_11_5_0101,
        72'h4F_FF_2_C0A5_4F_4F_2_0101,
        72'h00_C2_4_C825_C2_C2_0_0101,
        72'h33_00_0_C8A5_33_00_4_0101,
        72'h00_E6_0_CD25_CC_E6_1_0101,
        72'h77_01_1_CDA5_77_03_0_0101,
        72'h00_E6_1_CC25_F3_E6_0_0101,
        72'h00_01_0_CCA5_00_00_1_0101,
        72'h25_00_5_1F15_F0_00_2_0101,
        72'h02_03_0_C2A5_02_01_3_0101,
        72'h02_02_0_C2A5_02_00_7_0101,
        72'h02_01_7_C225_FF_01_0_0101,
        72'h00_A5_6_CE25_5A_A5_6_0101,
        72'h11_A5_1_CEA5_11_5A_1_0101,
        72'hB5_00_7_1DAF_1A_00_3_0101,
        72'h5A_00_0_1D5A_00_00_4_0101,
        72'hB5_AF_4_C6A5_B5_1A_0_0101,
        72'h3C_3C_0_C625_00_3C_4_0101,
        72'h12_34_5_0000_12_34_5_0101,
        72'h12_34_3_EABC_12_34_3_1ABC};

    mie_core dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .s_axi_awaddr_i(aa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(1'b1), .s_axi_araddr_i(ra), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .rom_addr_o(rom_addr),
        .rom_rd_o(rom_rd), .rom_data_i(rom_d), .wake_i(wk), .sleep_o(slp));
    mie_rom_model rom (.clk_sys_i(clk_sys_i), .rom_addr_i(rom_addr),
        .rom_rd_i(rom_rd), .rom_data_o(rom_d));

    always #5 clk_sys_i = ~clk_sys_i;

    // ****************
    // Tasks
    // ****************
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic tmo(input int n);
        if (n >= 40)
        begin
            n_errors++;
            $display("[ERR] %0t wait ran out", $time);
            results();
        end
    endtask : tmo

    // Ready and bready stay high, so each channel drops on its own edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        aa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
            n++;
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end
        while (bv !== 1'b1 && n < 40);
        r = bresp;
        tmo(n);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        ra <= a;
        arv <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
            n++;
            if (arr) arv <= 1'b0;
        end
        while (rv !== 1'b1 && n < 40);
        q = rdata;
        r = rresp;
        tmo(n);
    endtask : rd

    task automatic ex(input logic [15:0] op);
        int n;
        n = 0;
        wr(OFF_INSTR, {16'h0000, op});
        do
        begin
            rd(OFF_STATUS);
            n++;
        end
        while (q[SB_BUSY] !== 1'b0 && n < 20);
        tmo(n * 2);
    endtask : ex

    task automatic wt(input logic v);
        int n;
        n = 0;
        while (slp !== v && n < 40)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        tmo(n);
    endtask : wt

    // ****************
    // Sequence
    // ****************
    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(OFF_STATUS);
        chk(q, 32'h18);
        rd(8'h3C);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h30, 32'h1);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("reset and map test done");
        foreach (rows[i])
        begin
            wr(OFF_PC, 32'h100);
            wr(OFF_ACC, {24'h0, rows[i].a});
            wr(OFF_STATUS, {28'h0, rows[i].s});
            wr(OFF_FADDR, 32'h1A5);
            wr(OFF_FDATA, {24'h0, rows[i].f});
            ex(rows[i].op);
            rd(OFF_ACC);
            chk(q, {24'h0, rows[i].ea});
            rd(OFF_FDATA);
            chk(q, {24'h0, rows[i].ef});
            rd(OFF_STATUS);
            chk({28'h0, q[3:0]}, {28'h0, rows[i].es});
            rd(OFF_PC);
            chk(q, {16'h0, rows[i].pc});
            $display("row %0d done", i);
        end
        wr(OFF_STACK, 32'h555);
        ex(OPC_SUB_EXIT);
        rd(OFF_PC);
        chk(q, 32'h555);
        rd(OFF_DEPTH);
        chk(q, 32'h0);
        wr(OFF_STATUS, 32'h0);
        rd(OFF_STATUS);
        chk({31'h0, q[SB_GIE]}, 32'h0);
        wr(OFF_STACK, 32'hAAA);
        ex(OPC_IRQ_EXIT);
        rd(OFF_PC);
        chk(q, 32'hAAA);
        rd(OFF_STATUS);
        chk({31'h0, q[SB_GIE]}, 32'h1);
        wr(OFF_STACK, 32'h1234);
        ex(16'h18AB);
        rd(OFF_ACC);
        chk(q, 32'hAB);
        rd(OFF_PC);
        chk(q, 32'h1234);
        $display("stack exit test done");
        wr(OFF_TPTR_LO, 32'h34);
        wr(OFF_TPTR_HI, 32'h12);
        ex(OPC_TAB_LOW);
        rd(OFF_ACC);
        chk(q, 32'hCB);
        rd(OFF_TLATCH);
        chk(q, 32'hCB);
        ex(OPC_TAB_HIGH);
        rd(OFF_ACC);
        chk(q, 32'h34);
        rd(OFF_TLATCH);
        chk(q, 32'h34);
        $display("table test done");
        ex(OPC_SLEEP);
        wt(1'b1);
        rd(OFF_STATUS);
        chk({30'h0, q[SB_TO:SB_PD]}, 32'h2);
        wr(OFF_INSTR, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wk <= 1'b1;
        wt(1'b0);
        wk <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(OFF_STATUS);
        chk(q, 32'h18);
        $display("sleep and second reset test done");
        results();
    end
endmodule : test_mie_core
